// ===== hdl/link_ctrl.sv
// Streaming and repeater link-layer controller with APB registers
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module link_ctrl #(
	parameter int unsigned MS_CYC = link_pkg::MS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] serial_num,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic [8:0] in_level,
	output logic in_ready,
	output link_pkg::tx_byte_s tx_out,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire link_pkg::rx_hdr_s rx_hdr,
	input wire logic rx_hdr_valid,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_event_end,
	output logic host_valid,
	output logic [7:0] host_data,
	output logic rep_req,
	output link_pkg::pid_t rep_pid
);
	typedef enum logic [1:0] {T_IDLE, T_GET, T_PUT} tx_e;

	tx_e st_r;
	logic [2:0] mode_r;
	logic addr_en_r;
	logic [15:0] dest_r, mask_r, src_r, pks_r, thr_r, gap_lim_r, lim_r;
	logic [7:0] rn_r;
	logic [16:0] ms_cnt_r;
	logic ms_tick;
	logic [5:0] sl_cnt_r;
	logic slot_tick;
	logic [15:0] lfsr_r;
	logic [7:0] rmod;
	logic [15:0] pk_cnt_r, ev_cnt_r, gap_r;
	logic [8:0] lvl_q;
	logic first_r, done_r, limh_r;
	logic [7:0] ser_r;
	logic [8:0] hold_r;
	logic rpt_mode;
	logic [15:0] eff_pk;
	logic start_ok, ev_end;
	logic [15:0] pk_n, ev_n;
	link_pkg::rx_hdr_s hdr_q;
	logic chk_r, hit, dlv_r, mt, fresh;
	logic signed [9:0] nv;
	logic [8:0] nu, ds;
	logic [11:0] dv;
	logic [16:0] rep_ms_r;
	logic rep_pend_r;
	logic [19:0] resp_r;
	logic [11:0] resp_ds;
	logic hold_ld;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// APB slave, one wait state per access
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_r <= link_pkg::MODE_RST;
			addr_en_r <= 1'b0;
			dest_r <= link_pkg::DEST_RST;
			mask_r <= link_pkg::MASK_RST;
			src_r <= link_pkg::SRC_RST;
			pks_r <= link_pkg::PKS_RST;
			thr_r <= link_pkg::THR_RST;
			gap_lim_r <= link_pkg::GAP_RST;
			lim_r <= link_pkg::LIM_RST;
			rn_r <= link_pkg::SLOT_RST;
		end else if (psel & penable & pready & pwrite) begin
			case (paddr)
				link_pkg::OFF_CTRL: begin
					mode_r <= pwdata[link_pkg::CTRL_MODE_LSB +: 3];
					addr_en_r <= pwdata[link_pkg::CTRL_ADDR_BIT];
					if (pwdata[link_pkg::CTRL_AUTO_BIT]) begin
						src_r <= serial_num; // RULE21
					end
				end
				link_pkg::OFF_DEST: dest_r <= pwdata[15:0];
				link_pkg::OFF_MASK: mask_r <= pwdata[15:0];
				link_pkg::OFF_SRC: src_r <= pwdata[15:0];
				link_pkg::OFF_PKS: pks_r <= pwdata[15:0];
				link_pkg::OFF_THR: thr_r <= pwdata[15:0];
				link_pkg::OFF_GAP: gap_lim_r <= pwdata[15:0];
				link_pkg::OFF_LIM: lim_r <= pwdata[15:0];
				link_pkg::OFF_SLOT: rn_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel & penable & ~pready) begin
			pslverr <= 1'b0;
			case (paddr)
				link_pkg::OFF_CTRL: prdata <= {16'h0, link_pkg::RETRY_ZERO, 4'h0, addr_en_r,
					mode_r}; // RULE3
				link_pkg::OFF_DEST: prdata <= {16'h0, dest_r};
				link_pkg::OFF_MASK: prdata <= {16'h0, mask_r};
				link_pkg::OFF_SRC: prdata <= {16'h0, src_r};
				link_pkg::OFF_PKS: prdata <= {16'h0, pks_r};
				link_pkg::OFF_THR: prdata <= {16'h0, thr_r};
				link_pkg::OFF_GAP: prdata <= {16'h0, gap_lim_r};
				link_pkg::OFF_LIM: prdata <= {16'h0, lim_r};
				link_pkg::OFF_SLOT: prdata <= {24'h0, rn_r};
				link_pkg::OFF_STAT: prdata <= {16'h0, ser_r, 5'h0, rep_pend_r, |hold_r,
					st_r != T_IDLE};
				default: begin
					prdata <= 32'h0;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// Millisecond and slot enables, random source
	// Slot timing restarts when a hold-off is loaded so every slot is whole
	assign hold_ld = ev_end || (rx_event_end && st_r == T_IDLE && rn_r != 8'h0 && hold_r == 9'h0);

	always_ff @(posedge clk) begin
		if (rst || hold_ld) begin
			ms_cnt_r <= '0;
			ms_tick <= 1'b0;
		end else if (ms_cnt_r == 17'(MS_CYC - 1)) begin
			ms_cnt_r <= '0;
			ms_tick <= 1'b1;
		end else begin
			ms_cnt_r <= ms_cnt_r + 1'b1;
			ms_tick <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || hold_ld) begin
			sl_cnt_r <= '0;
			slot_tick <= 1'b0;
		end else begin
			slot_tick <= 1'b0;
			if (ms_tick) begin
				if (sl_cnt_r == 6'(link_pkg::SLOT_MS - 1)) begin
					sl_cnt_r <= '0;
					slot_tick <= 1'b1; // RULE23
				end else begin
					sl_cnt_r <= sl_cnt_r + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lfsr_r <= link_pkg::LFSR_SEED;
		end else begin
			lfsr_r <= {lfsr_r[14:0], ^(lfsr_r & link_pkg::LFSR_TAPS)}; // RULE24
		end
	end

	// Uniform enough for small N; 0..N-1, zero when N is zero
	assign rmod = (rn_r == 8'h0) ? 8'h0 : lfsr_r[7:0] % rn_r;

	// ==========================================================
	// Transmit event sequencing
	assign rpt_mode = (mode_r == link_pkg::MODE_RPT) || (mode_r == link_pkg::MODE_DST);
	assign eff_pk = (rpt_mode && pks_r > link_pkg::RPT_MAX) ? link_pkg::RPT_MAX : pks_r; // RULE13
	assign start_ok = (hold_r == 9'h0) && !(rpt_mode && resp_r != 20'h0) && (in_level != 9'h0)
		&& ({7'h0, in_level} >= thr_r || gap_r >= gap_lim_r); // RULE4 RULE11 RULE19
	assign pk_n = pk_cnt_r + 1'b1;
	assign ev_n = ev_cnt_r + 1'b1;
	assign ev_end = (st_r == T_PUT) && tx_ready && tx_out.eop && done_r;

	// Serial gap timer restarts whenever the input level moves
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_q <= '0;
			gap_r <= '0;
		end else begin
			lvl_q <= in_level;
			if (in_level != lvl_q || in_level == 9'h0) begin
				gap_r <= '0;
			end else if (ms_tick && gap_r != 16'hffff) begin
				gap_r <= gap_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= T_IDLE;
			in_ready <= 1'b0;
			tx_valid <= 1'b0;
			tx_out <= '0;
			pk_cnt_r <= '0;
			ev_cnt_r <= '0;
			first_r <= 1'b0;
			done_r <= 1'b0;
			limh_r <= 1'b0;
			ser_r <= '0;
		end else begin
			case (st_r)
				T_IDLE: begin
					if (start_ok) begin
						st_r <= T_GET;
						in_ready <= 1'b1;
						first_r <= 1'b1;
						pk_cnt_r <= '0;
						ev_cnt_r <= '0;
					end
				end
				T_GET: begin
					if (in_valid) begin
						in_ready <= 1'b0;
						tx_valid <= 1'b1;
						tx_out.data <= in_data;
						tx_out.sop <= pk_cnt_r == 16'h0;
						tx_out.eop <= ev_n >= lim_r || in_level <= 9'h1 || pk_n >= eff_pk; // RULE6
						tx_out.init <= first_r; // RULE8
						tx_out.dest <= dest_r;
						tx_out.src <= src_r; // RULE14
						tx_out.serial <= ser_r;
						done_r <= ev_n >= lim_r || in_level <= 9'h1; // RULE5
						limh_r <= ev_n >= lim_r;
						pk_cnt_r <= pk_n;
						ev_cnt_r <= ev_n;
						st_r <= T_PUT;
					end
				end
				T_PUT: begin
					if (tx_ready) begin
						tx_valid <= 1'b0;
						if (tx_out.eop) begin
							ser_r <= ser_r + 1'b1; // RULE14
							pk_cnt_r <= '0;
							first_r <= 1'b0;
						end
						if (tx_out.eop && done_r) begin
							st_r <= T_IDLE;
						end else begin
							st_r <= T_GET; // RULE5
							in_ready <= 1'b1;
						end
					end
				end
				default: st_r <= T_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Slot hold-off after events
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_r <= '0;
		end else if (ev_end) begin
			if (limh_r) begin
				hold_r <= (rn_r == 8'h0) ? 9'h1 : {1'b0, rmod} + 9'h1; // RULE7
			end else begin
				hold_r <= {1'b0, rn_r}; // RULE9
			end
		end else if (rx_event_end && st_r == T_IDLE && rn_r != 8'h0 && hold_r == 9'h0) begin
			hold_r <= {1'b0, rmod}; // RULE10
		end else if (slot_tick && hold_r != 9'h0) begin
			hold_r <= hold_r - 1'b1;
		end
	end

	// ==========================================================
	// Receive filtering and duplicate suppression
	pid_hist u_hist (
		.clk(clk),
		.rst(rst),
		.look_id({rx_hdr.src, rx_hdr.serial}),
		.wr_en(fresh),
		.wr_id({hdr_q.src, hdr_q.serial}),
		.hit(hit)
	);

	// Payload must begin at least two cycles after its header
	always_ff @(posedge clk) begin
		if (rst) begin
			hdr_q <= '0;
			chk_r <= 1'b0;
		end else begin
			chk_r <= rx_hdr_valid;
			if (rx_hdr_valid) begin
				hdr_q <= rx_hdr;
			end
		end
	end

	assign fresh = chk_r && !hit; // RULE15
	assign mt = (hdr_q.dest == link_pkg::GLOBAL_ADDR)
		|| ((hdr_q.dest & mask_r) == src_r); // RULE17 RULE22

	always_ff @(posedge clk) begin
		if (rst) begin
			dlv_r <= 1'b0;
		end else if (rx_hdr_valid) begin
			dlv_r <= 1'b0;
		end else if (chk_r) begin
			dlv_r <= fresh && ((rpt_mode || addr_en_r) ? mt : 1'b1); // RULE1 RULE2 RULE16
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			host_valid <= 1'b0;
			host_data <= '0;
		end else begin
			host_valid <= rx_valid && dlv_r; // RULE2
			host_data <= rx_data;
		end
	end

	// ==========================================================
	// Repeat back-off and response delay
	assign nv = 10'(link_pkg::RSSI_REF) - {{2{hdr_q.rssi[7]}}, hdr_q.rssi};
	assign nu = nv[9] ? 9'h0 : nv[8:0];
	assign dv = 12'(rn_r) * 12'(link_pkg::SLOT_DIV);
	assign ds = (rn_r == 8'h0) ? 9'h0 : 9'({3'h0, nu} / dv) + {1'b0, rmod}; // RULE18
	assign resp_ds = 12'(link_pkg::RESP_K) * {4'h0, rn_r} + {4'h0, rn_r} + 12'h1; // RULE19

	// A newer packet replaces a pending repeat; hosts feed one at a time
	always_ff @(posedge clk) begin
		if (rst) begin
			rep_pend_r <= 1'b0;
			rep_ms_r <= '0;
			rep_req <= 1'b0;
			rep_pid <= '0;
		end else begin
			rep_req <= 1'b0;
			if (fresh && mode_r == link_pkg::MODE_RPT) begin
				rep_pend_r <= 1'b1; // RULE12 RULE16 RULE13
				rep_ms_r <= 17'(hdr_q.air_ms) * 17'(ds); // RULE18
				rep_pid <= {hdr_q.src, hdr_q.serial};
			end else if (rep_pend_r && rep_ms_r == 17'h0) begin
				rep_pend_r <= 1'b0;
				rep_req <= 1'b1; // RULE11
			end else if (rep_pend_r && ms_tick) begin
				rep_ms_r <= rep_ms_r - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			resp_r <= '0;
		end else if (fresh && rpt_mode) begin
			resp_r <= 20'(hdr_q.air_ms) * 20'(resp_ds); // RULE19
		end else if (ms_tick && resp_r != 20'h0) begin
			resp_r <= resp_r - 1'b1;
		end
	end

	// ==========================================================
	// Checks
	sequence s_fresh;
		chk_r && !hit;
	endsequence

	sequence s_dup;
		chk_r && hit;
	endsequence

	a_retry_read_zero: assert property (pready && paddr == link_pkg::OFF_CTRL && !pwrite
		|-> prdata[15:8] == 8'h0) else $error("retry field not zero"); // RULE3

	a_pkt_size_cap: assert property (tx_valid && tx_out.eop |-> pk_cnt_r <= eff_pk
		&& pk_cnt_r != 16'h0) else $error("packet too long"); // RULE6

	a_later_no_init: assert property ($rose(tx_valid) && tx_out.sop && ev_cnt_r > pk_cnt_r
		|-> !tx_out.init) else $error("initializer on later packet"); // RULE8

	a_dup_ignored: assert property (s_dup |=> !dlv_r && !rep_pend_r [*2])
		else $error("duplicate accepted"); // RULE15

	a_global_deliver: assert property (s_fresh ##0 hdr_q.dest == link_pkg::GLOBAL_ADDR
		|=> dlv_r) else $error("global not delivered"); // RULE17

	a_nomatch_repeat: assert property (s_fresh ##0 !mt ##0 mode_r == link_pkg::MODE_RPT
		|=> !dlv_r && rep_pend_r) else $error("no-match handling wrong"); // RULE16

	a_limit_backoff: assert property (ev_end && limh_r |=> hold_r >= 9'h1
		&& hold_r <= ((rn_r == 8'h0) ? 9'h1 : {1'b0, rn_r})) else $error("limit back-off"); // RULE7

	a_end_exact_hold: assert property (ev_end && !limh_r |=> hold_r == {1'b0, $past(rn_r)})
		else $error("end hold not N"); // RULE9

	a_auto_src: assert property (psel && penable && pready && pwrite && paddr ==
		link_pkg::OFF_CTRL && pwdata[4] |=> src_r == $past(serial_num))
		else $error("auto address not set"); // RULE21
endmodule : link_ctrl

// ===== hdl/link_pkg.sv
// Constants, register map and carrier types for the radio link controller
// Functional notes
// RULE1: Broadcast mode passes every received packet straight to the host.
// RULE2: Addressed mode passes payload only when the address check passes.
// RULE3: Streaming retry count is zero; no acknowledgments are ever sent.
// RULE4: Byte threshold and serial gap timeout gate only the first packet.
// RULE5: An event keeps sending until input empties or byte limit is hit.
// RULE6: No packet payload exceeds the maximum packet size.
// RULE7: Byte limit reached: wait random 1..N slots, or 1 slot when N is 0.
// RULE8: Later packets of one event carry no RF initializer.
// RULE9: Sender waits exactly N slots after its event when N is nonzero.
// RULE10: Receiver holds off random 0..N-1 slots after another's event.
// RULE11: Mode 3 repeats and receives; mode 4 receives and waits out repeats.
// RULE12: A repeater retransmits any packet at most once.
// RULE13: Repeater packets stay within 256 bytes; host feeds one at a time.
// RULE14: Packet identifier is source address plus per-sender serial number.
// RULE15: Eight-entry FIFO of identifiers; known identifiers are ignored.
// RULE16: Address match gives host output and repeat; no match repeats only.
// RULE17: Destination 0xFFFF is global and delivered by every node.
// RULE18: Repeat back-off is L times ((-41-RSSI)/(10N) plus random 0..N-1) ms.
// RULE19: Host data waits L times (14N+N+1) ms so pending repeats finish.
// RULE20: Use zero slots for small networks, one for 2 to 5 repeaters.
// RULE21: Source addresses are unique; auto-set copies the module serial number.
// RULE22: Receiver ANDs destination with its mask and compares with own address.
// RULE23: One delay slot lasts 38 ms.
// RULE24: Random slot counts come from a free-running LFSR.
package link_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
	localparam int unsigned SLOT_MS = 38;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DEST = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_SRC = 8'h0c;
	localparam logic [7:0] OFF_PKS = 8'h10;
	localparam logic [7:0] OFF_THR = 8'h14;
	localparam logic [7:0] OFF_GAP = 8'h18;
	localparam logic [7:0] OFF_LIM = 8'h1c;
	localparam logic [7:0] OFF_SLOT = 8'h20;
	localparam logic [7:0] OFF_STAT = 8'h24;
	// ==========================================================
	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ADDR_BIT = 3;
	localparam int CTRL_AUTO_BIT = 4;
	localparam logic [7:0] RETRY_ZERO = 8'h00;
	// ==========================================================
	// Reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [15:0] DEST_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'hffff;
	localparam logic [15:0] SRC_RST = 16'hffff;
	localparam logic [15:0] PKS_RST = 16'h0040;
	localparam logic [15:0] THR_RST = 16'h0040;
	localparam logic [15:0] GAP_RST = 16'h0003;
	localparam logic [15:0] LIM_RST = 16'hffff;
	localparam logic [7:0] SLOT_RST = 8'h00;
	// ==========================================================
	// Network constants
	localparam logic [2:0] MODE_RPT = 3'h3;
	localparam logic [2:0] MODE_DST = 3'h4;
	localparam logic [15:0] GLOBAL_ADDR = 16'hffff;
	localparam logic [15:0] RPT_MAX = 16'h0100;
	localparam int RSSI_REF = -41;
	localparam int RSSI_WORST = -100;
	localparam int SLOT_DIV = 10;
	localparam int RESP_K = (-RSSI_REF - RSSI_WORST) / SLOT_DIV;
	localparam int PID_DEPTH = 8;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [15:0] LFSR_TAPS = 16'hb400;
	// ==========================================================
	// Carriers
	typedef logic [23:0] pid_t;
	typedef struct packed {
		logic [15:0] dest;
		logic [15:0] src;
		logic [7:0] serial;
		logic [7:0] rssi;
		logic [7:0] air_ms;
	} rx_hdr_s;
	typedef struct packed {
		logic [7:0] data;
		logic sop;
		logic eop;
		logic init;
		logic [15:0] dest;
		logic [15:0] src;
		logic [7:0] serial;
	} tx_byte_s;
endpackage : link_pkg

// ===== hdl/pid_hist.sv
// Eight-entry FIFO history of packet identifiers with registered lookup
`timescale 1ns/1ps
module pid_hist (
	input wire logic clk,
	input wire logic rst,
	input wire link_pkg::pid_t look_id,
	input wire logic wr_en,
	input wire link_pkg::pid_t wr_id,
	output logic hit
);
	localparam int AW = $clog2(link_pkg::PID_DEPTH);
	link_pkg::pid_t ids_r [link_pkg::PID_DEPTH];
	logic [link_pkg::PID_DEPTH-1:0] vld_r;
	logic [link_pkg::PID_DEPTH-1:0] eq;
	logic [AW-1:0] wp_r;

	for (genvar i = 0; i < link_pkg::PID_DEPTH; i++) begin : g_cmp
		assign eq[i] = vld_r[i] && (ids_r[i] == look_id); // RULE15
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hit <= 1'b0;
		end else begin
			hit <= |eq;
		end
	end

	// Oldest entry is overwritten first
	always_ff @(posedge clk) begin
		if (rst) begin
			vld_r <= '0;
			wp_r <= '0;
		end else if (wr_en) begin
			vld_r[wp_r] <= 1'b1;
			wp_r <= wp_r + 1'b1; // RULE15
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en) begin
			ids_r[wp_r] <= wr_id;
		end
	end
endmodule : pid_hist

// ===== verif/peer_radio.sv
// Peer radio model: injects received packets and sinks transmitted bytes
`timescale 1ns/1ps
module peer_radio (
	input wire logic clk,
	input wire logic rst,
	input wire link_pkg::tx_byte_s tx_out,
	input wire logic tx_valid,
	output logic tx_ready,
	output link_pkg::rx_hdr_s rx_hdr,
	output logic rx_hdr_valid,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_event_end
);
	link_pkg::tx_byte_s txq[0:63];
	int txn;
	logic [2:0] stall_r;
	initial begin
		tx_ready = 1'b0;
		rx_hdr = '0;
		rx_hdr_valid = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_event_end = 1'b0;
		stall_r = 3'h0;
		txn = 0;
	end
	// ==========================================================
	// Sink: stalls one cycle in eight, never answers with an acknowledgment
	always @(posedge clk) begin
		stall_r <= stall_r + 3'h1;
		tx_ready <= stall_r != 3'h5;
		if (tx_valid && tx_ready) begin
			txq[txn[5:0]] <= tx_out;
			txn <= txn + 1;
		end
	end
	// ==========================================================
	// Sender: one short packet at a time, lines inverted once released
	task automatic send(input link_pkg::rx_hdr_s h, input int n, input logic [7:0] b);
		@(posedge clk);
		rx_hdr <= h;
		rx_hdr_valid <= 1'b1;
		@(posedge clk);
		rx_hdr_valid <= 1'b0;
		rx_hdr <= ~h;
		repeat (2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data <= b + 8'(i);
			@(posedge clk);
			rx_valid <= 1'b0;
			rx_data <= ~(b + 8'(i));
			@(posedge clk);
		end
		rx_event_end <= 1'b1;
		@(posedge clk);
		rx_event_end <= 1'b0;
	endtask : send
endmodule : peer_radio

// ===== verif/test_link_ctrl.sv
// Self-checking bench for the link controller with a peer radio model
`timescale 1ns/1ps
module test_link_ctrl;
	localparam int MSC = 10;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, in_ready;
	logic tx_valid, tx_ready, rx_hdr_valid, rx_valid, rx_event_end, host_valid, rep_req;
	logic [7:0] paddr, rx_data, host_data;
	logic [31:0] pwdata, prdata;
	link_pkg::tx_byte_s tx_out;
	link_pkg::rx_hdr_s rx_hdr;
	link_pkg::pid_t rep_pid, last_pid;
	logic [7:0] ibuf[0:31];
	logic [7:0] hq[0:255];
	logic [31:0] rv[9] = '{32'h0, 32'h0, 32'hffff, 32'hffff, 32'h40, 32'h40, 32'h3, 32'hffff, 32'h0};
	int hd, tl, hn, rn, err_count, samples_checked;
	wire in_valid = tl > hd;
	wire [7:0] in_data = ibuf[hd[4:0]];
	wire [8:0] in_level = 9'(tl - hd);
	link_ctrl #(.MS_CYC(MSC)) uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_num(16'h5a3c), .in_valid, .in_data, .in_level,
		.in_ready, .tx_out, .tx_valid, .tx_ready, .rx_hdr, .rx_hdr_valid, .rx_valid,
		.rx_data, .rx_event_end, .host_valid, .host_data, .rep_req, .rep_pid);
	peer_radio peer (.clk, .rst, .tx_out, .tx_valid, .tx_ready, .rx_hdr, .rx_hdr_valid,
		.rx_valid, .rx_data, .rx_event_end);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// Input buffer, host output and repeat monitors
	always @(posedge clk) begin
		if (in_valid && in_ready)
			hd <= hd + 1;
		if (host_valid) begin
			hq[hn[7:0]] <= host_data;
			hn <= hn + 1;
		end
		if (rep_req) begin
			rn <= rn + 1;
			last_pid <= rep_pid;
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Look at the settled ready mid-cycle; it completes at the next rising edge
		@(negedge clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk);
		end
		if (n >= 50)
			err_count++;
		q = prdata;
		e = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk($sformatf("reg %h", a), x, q);
	endtask : rd
	task automatic load(input int n, input logic [7:0] b);
		for (int i = 0; i < n; i++)
			ibuf[5'(tl + i)] = b + 8'(i);
		tl <= tl + n;
		@(posedge clk);
	endtask : load
	task automatic wait_tx(input int c);
		int k;
		k = 0;
		while (peer.txn < c && k < 3000) begin
			k++;
			@(posedge clk);
		end
		if (k >= 3000)
			err_count++;
	endtask : wait_tx
	task automatic pk(input int f, input int n, input logic [7:0] b, input int p);
		link_pkg::tx_byte_s t;
		logic [7:0] s0;
		logic [31:0] x;
		logic [31:0] g;
		s0 = peer.txq[f].serial;
		chk("tx src", 32'h5a3c, 32'(peer.txq[f].src));
		for (int j = 0; j < n; j++) begin
			t = peer.txq[f + j];
			x = {8'(j / p), b + 8'(j), 5'h0, j % p == 0, j % p == p - 1 || j == n - 1, j < p};
			g = {t.serial - s0, t.data, 5'h0, t.sop, t.eop, t.init};
			chk("tx byte", x, g);
		end
	endtask : pk
	task automatic rx(input logic [15:0] d, input logic [7:0] s, input logic h, input logic r);
		int b;
		int c;
		link_pkg::rx_hdr_s x;
		b = hn;
		c = rn;
		x = '{d, 16'h0009, s, 8'hd0, 8'h01};
		peer.send(x, 2, s);
		repeat (6) @(posedge clk);
		chk("host bytes", h ? 32'h2 : 32'h0, 32'(hn - b));
		if (h)
			chk("host data", {s + 8'h1, s}, {hq[8'(b + 1)], hq[8'(b)]});
		chk("repeats", 32'(r), 32'(rn - c));
		if (r)
			chk("repeat id", {16'h0009, s}, last_pid);
	endtask : rx
	task automatic final_report();
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// ==========================================================
	// Watchdog
	initial begin
		repeat (50000) @(posedge clk);
		err_count++;
		final_report();
	end
	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic e;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{hd, tl, hn, rn, err_count, samples_checked} = '0;
		last_pid = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 9; i++)
			rd(8'(4 * i), rv[i]);
		apb(1'b0, 8'h28, 32'h0, q, e);
		chk("slverr", 32'h1, 32'(e));
		wr(8'h00, 32'h10);
		rd(8'h0c, 32'h5a3c);
		wr(8'h00, 32'h500);
		rd(8'h00, 32'h0);
		wr(8'h10, 32'h4);
		load(10, 8'h20);
		wait_tx(10);
		pk(0, 10, 8'h20, 4);
		wr(8'h1c, 32'h6);
		load(10, 8'h40);
		wait_tx(16);
		repeat (MSC * 30) @(posedge clk);
		chk("held bytes", 32'h10, 32'(peer.txn));
		wait_tx(20);
		pk(10, 6, 8'h40, 4);
		pk(16, 4, 8'h46, 4);
		rx(16'h1235, 8'h01, 1'b1, 1'b0);
		wr(8'h08, 32'hff);
		wr(8'h0c, 32'h34);
		wr(8'h00, 32'h8);
		rx(16'h1235, 8'h02, 1'b0, 1'b0);
		rx(16'h1234, 8'h03, 1'b1, 1'b0);
		rx(16'hffff, 8'h04, 1'b1, 1'b0);
		wr(8'h00, 32'h3);
		wr(8'h20, 32'h0);
		for (int k = 0; k < 8; k++)
			rx(k[0] ? 16'h1299 : 16'h1234, 8'h10 + 8'(k), !k[0], 1'b1);
		rx(16'h1234, 8'h17, 1'b0, 1'b0);
		rx(16'h1234, 8'h18, 1'b1, 1'b1);
		rx(16'h1234, 8'h10, 1'b1, 1'b1);
		wr(8'h00, 32'h4);
		rx(16'h1234, 8'h20, 1'b1, 1'b0);
		final_report();
	end
endmodule : test_link_ctrl
